//--- core/gcs_core.sv
// Broadcast sync I2C slave of a converter with conversion timing.
// Assumes SCL and SDA are open-drain pins sampled by the system clock.
`timescale 1ns/1ps
`default_nettype none
`include "gcs_map.svh"
module gcs_core
  import gcs_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = `GCS_CONV_CYCLES
) (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_n_i,
  // I2C pins
  input  wire logic       scl_i,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe_o,
  // Straps and clock source
  input  wire logic [6:0] own_addr_i,
  input  wire logic       use_ext_clk_i,
  input  wire logic       ext_clk_i,
  // Converter side
  output logic            conv_busy_o,
  output logic            conv_start_o,
  output logic [7:0]      chan_o,
  output logic [7:0]      cfg_o,
  output logic            sw_en_o,
  input  wire logic [7:0] rd_data_i
);
  if (CONV_CYCLES < 2) begin : g_bad_conv
    $error("CONV_CYCLES too small");
  end
  // ==========================================================
  // Synchronisers
  logic [1:0] scl_s_q, sda_s_q, ext_s_q;
  logic       scl_p_q, sda_p_q, ext_p_q;
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_s_q <= 2'h3;
      sda_s_q <= 2'h3;
      ext_s_q <= 2'h0;
      scl_p_q <= 1'b1;
      sda_p_q <= 1'b1;
      ext_p_q <= 1'b0;
    end else begin
      scl_s_q <= {scl_s_q[0], scl_i};
      sda_s_q <= {sda_s_q[0], sda_i};
      ext_s_q <= {ext_s_q[0], ext_clk_i};
      scl_p_q <= scl_s_q[1];
      sda_p_q <= sda_s_q[1];
      ext_p_q <= ext_s_q[1];
    end
  end
  logic scl, sda, scl_rise, scl_fall, start_c, stop_c, ext_edge;
  assign scl      = scl_s_q[1];
  assign sda      = sda_s_q[1];
  assign scl_rise = scl & ~scl_p_q;
  assign scl_fall = ~scl & scl_p_q;
  assign start_c  = scl & scl_p_q & sda_p_q & ~sda;
  assign stop_c   = scl & scl_p_q & ~sda_p_q & sda;
  assign ext_edge = ext_s_q[1] & ~ext_p_q;
  // ==========================================================
  // Slave state
  gcs_state_e  st_q, st_d;
  logic [7:0]  sh_q, sh_d;
  logic [3:0]  bit_q, bit_d;
  logic        drv_q, drv_d;
  logic        sel_q, sel_d;
  logic [1:0]  nbyte_q, nbyte_d;
  logic [7:0]  chan_q, chan_d, cfg_q, cfg_d;
  logic [7:0]  pch_q, pch_d, pcf_q, pcf_d;
  logic [1:0]  pn_q, pn_d;
  logic        busy_q, busy_d, strt_q, strt_d;
  logic [31:0] cc_q, cc_d;
  logic        addr_hit, glob_hit;
  assign glob_hit = sh_q[7:1] == `GCS_GLOBAL_ADDR;
  assign addr_hit = glob_hit | (sh_q[7:1] == own_addr_i);
  always_comb begin
    st_d    = st_q;
    sh_d    = sh_q;
    bit_d   = bit_q;
    drv_d   = drv_q;
    sel_d   = sel_q;
    nbyte_d = nbyte_q;
    chan_d  = chan_q;
    cfg_d   = cfg_q;
    pch_d   = pch_q;
    pcf_d   = pcf_q;
    pn_d    = pn_q;
    busy_d  = busy_q;
    strt_d  = 1'b0;
    cc_d    = cc_q;
    if (busy_q) begin
      if (cc_q == CONV_CYCLES - 1) begin
        busy_d = 1'b0;
        cc_d   = 32'h0;
      end else begin
        cc_d = cc_q + 32'h1;
      end
    end
    if (start_c) begin
      st_d  = GCS_ADDR;
      bit_d = 4'h0;
      drv_d = 1'b0;
      pn_d  = 2'h0;
    end else if (stop_c) begin
      if (sel_q && !busy_q) begin
        strt_d = 1'b1;
        busy_d = 1'b1;
        cc_d   = 32'h0;
        if (pn_q != 2'h0) begin
          chan_d = pch_q;
        end
        if (pn_q == 2'h2) begin
          cfg_d = pcf_q;
        end
      end
      st_d  = GCS_IDLE;
      sel_d = 1'b0;
      drv_d = 1'b0;
      pn_d  = 2'h0;
    end else begin
      unique case (st_q)
        GCS_IDLE: begin
          drv_d = 1'b0;
        end
        GCS_ADDR, GCS_DATA: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda};
            bit_d = bit_q + 4'h1;
          end else if (scl_fall && bit_q == 4'h8) begin
            bit_d = 4'h0;
            if (st_q == GCS_ADDR) begin
              st_d = GCS_AACK;
              drv_d = addr_hit && !busy_q && !(glob_hit && sh_q[0]);
              sel_d = addr_hit && !busy_q && !(glob_hit && sh_q[0]);
              nbyte_d = 2'h0;
            end else begin
              st_d  = GCS_DACK;
              drv_d = 1'b1;
              if (nbyte_q == 2'h0) begin
                pch_d = sh_q;
                pn_d  = 2'h1;
              end else if (nbyte_q == 2'h1) begin
                pcf_d = sh_q;
                pn_d  = 2'h2;
              end
              if (nbyte_q != 2'h3) begin
                nbyte_d = nbyte_q + 2'h1;
              end
            end
          end
        end
        GCS_AACK, GCS_DACK: begin
          if (scl_fall) begin
            drv_d = 1'b0;
            if (!sel_q) begin
              st_d = GCS_WAIT;
            end else if (st_q == GCS_AACK && sh_q[0]) begin
              st_d  = GCS_READ;
              sh_d  = rd_data_i;
              drv_d = ~rd_data_i[7];
            end else begin
              st_d = GCS_DATA;
            end
          end
        end
        GCS_READ: begin
          if (scl_fall) begin
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h7) begin
              drv_d = 1'b0;
            end else if (bit_q == 4'h8) begin
              bit_d = 4'h0;
              drv_d = ~sh_q[7];
            end else begin
              sh_d  = {sh_q[6:0], 1'b1};
              drv_d = ~sh_q[6];
            end
          end else if (scl_rise && bit_q == 4'h8 && sda) begin
            st_d = GCS_WAIT;
          end
        end
        GCS_WAIT: begin
          drv_d = 1'b0;
        end
        default: begin
          st_d  = GCS_IDLE;
          drv_d = 1'b0;
        end
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      st_q    <= GCS_IDLE;
      sh_q    <= 8'h00;
      bit_q   <= 4'h0;
      drv_q   <= 1'b0;
      sel_q   <= 1'b0;
      nbyte_q <= 2'h0;
      chan_q  <= `GCS_CHAN_RESET;
      cfg_q   <= `GCS_CFG_RESET;
      pch_q   <= 8'h00;
      pcf_q   <= 8'h00;
      pn_q    <= 2'h0;
      busy_q  <= 1'b1;
      strt_q  <= 1'b0;
      cc_q    <= 32'h0;
    end else begin
      st_q    <= st_d;
      sh_q    <= sh_d;
      bit_q   <= bit_d;
      drv_q   <= drv_d;
      sel_q   <= sel_d;
      nbyte_q <= nbyte_d;
      chan_q  <= chan_d;
      cfg_q   <= cfg_d;
      pch_q   <= pch_d;
      pcf_q   <= pcf_d;
      pn_q    <= pn_d;
      busy_q  <= busy_d;
      strt_q  <= strt_d;
      cc_q    <= cc_d;
    end
  end
  // ==========================================================
  // Sampling switch enable
  logic sw_en_c, sw_q, sw_d;
  gcs_sw_div #(
    .INT_DIV (`GCS_SW_INT_DIV)
  ) u_div (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .run_i      (busy_q),
    .use_ext_i  (use_ext_clk_i),
    .ext_edge_i (ext_edge),
    .sw_en_o    (sw_en_c)
  );
  // Drop a pulse that would land after busy has fallen
  always_comb begin
    sw_d = sw_en_c & busy_q;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sw_q <= 1'b0;
    end else begin
      sw_q <= sw_d;
    end
  end
  assign sda_o        = 1'b0;
  assign sda_oe_o     = drv_q;
  assign conv_busy_o  = busy_q;
  assign conv_start_o = strt_q;
  assign chan_o       = chan_q;
  assign cfg_o        = cfg_q;
  assign sw_en_o      = sw_q;
endmodule
`default_nettype wire

//--- core/gcs_map.svh
// Constants for the broadcast sync I2C slave: addresses and timing.
// Assumes a 200 MHz system clock; included by the core, the divider and the bench.
`ifndef GCS_MAP_SVH
`define GCS_MAP_SVH
`define GCS_GLOBAL_ADDR      7'h77
`define GCS_CFG_RESET        8'h00
`define GCS_CHAN_RESET       8'h80
`define GCS_CLK_HZ           200000000
`define GCS_SW_INT_HZ        123000
`define GCS_SW_INT_DIV       (`GCS_CLK_HZ / `GCS_SW_INT_HZ)
`define GCS_CONV_CYCLES      32'd200000
`endif

//--- core/gcs_pkg.sv
// Types for the broadcast sync I2C slave.
// Assumes nothing beyond the constants header.
package gcs_pkg;
  typedef enum logic [2:0] {
    GCS_IDLE  = 3'b000,
    GCS_ADDR  = 3'b001,
    GCS_AACK  = 3'b011,
    GCS_DATA  = 3'b010,
    GCS_DACK  = 3'b110,
    GCS_READ  = 3'b111,
    GCS_WAIT  = 3'b101
  } gcs_state_e;
endpackage

//--- core/gcs_sw_div.sv
// Sampling switch enable divider, internal or external clock.
// Assumes ext_edge_i is a one-cycle pulse per external clock rising edge.
`timescale 1ns/1ps
`default_nettype none
`include "gcs_map.svh"
module gcs_sw_div #(
  parameter int unsigned INT_DIV = `GCS_SW_INT_DIV
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  // Control
  input  wire logic run_i,
  input  wire logic use_ext_i,
  input  wire logic ext_edge_i,
  // Output
  output logic      sw_en_o
);
  // Divider must fit the 16-bit counter
  if (INT_DIV < 2 || INT_DIV > 65536) begin : g_bad_div
    $error("INT_DIV out of range");
  end
  logic [15:0] cnt_q, cnt_d;
  logic [2:0]  acc_q, acc_d;
  logic        en_q, en_d;
  // ==========================================================
  // Next state
  always_comb begin
    cnt_d = cnt_q;
    acc_d = acc_q;
    en_d  = 1'b0;
    if (!run_i) begin
      cnt_d = 16'h0000;
      acc_d = 3'h0;
    end else if (use_ext_i) begin
      if (ext_edge_i) begin
        if (acc_q >= 3'h3) begin
          acc_d = acc_q - 3'h3;
          en_d  = 1'b1;
        end else begin
          acc_d = acc_q + 3'h2;
        end
      end
    end else if (cnt_q == 16'(INT_DIV - 1)) begin
      cnt_d = 16'h0000;
      en_d  = 1'b1;
    end else begin
      cnt_d = cnt_q + 16'h0001;
    end
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q <= 16'h0000;
      acc_q <= 3'h0;
      en_q  <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      acc_q <= acc_d;
      en_q  <= en_d;
    end
  end
  assign sw_en_o = en_q;
endmodule
`default_nettype wire

//--- verif/gcs_core_checker.sv
// Checker for the broadcast sync slave, bound to gcs_core.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module gcs_core_checker
  import gcs_pkg::*;
#(
  parameter int unsigned CONV_CYCLES = 50
) (
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_n_i,
  // Pins and straps
  input wire logic       scl_i,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe_o,
  input wire logic [6:0] own_addr_i,
  input wire logic       use_ext_clk_i,
  input wire logic       ext_clk_i,
  // Converter side
  input wire logic       conv_busy_o,
  input wire logic       conv_start_o,
  input wire logic [7:0] chan_o,
  input wire logic [7:0] cfg_o,
  input wire logic       sw_en_o,
  input wire logic [7:0] rd_data_i
);
  // ==========================================
  // Busy length counter
  logic [31:0] cnt_q;
  logic [31:0] cnt_d;
  logic        seen_q;
  logic        seen_d;
  always_comb begin
    cnt_d  = conv_start_o ? 32'h1 : (conv_busy_o ? cnt_q + 32'h1 : cnt_q);
    seen_d = seen_q | conv_start_o;
  end
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt_q  <= 32'h0;
      seen_q <= 1'b0;
    end else begin
      cnt_q  <= cnt_d;
      seen_q <= seen_d;
    end
  end
  // ==========================================
  // Properties
  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  a_start_busy: assert property (conv_start_o |-> conv_busy_o)
    else $error("start without busy");
  a_start_pulse: assert property (conv_start_o |=> !conv_start_o)
    else $error("start longer than one cycle");
  a_start_stop: assert property (conv_start_o |-> scl_i && sda_i)
    else $error("start not after a stop");
  a_busy_len: assert property (seen_q && $fell(conv_busy_o) |->
    cnt_q == CONV_CYCLES) else $error("busy length wrong");
  a_cfg_only_start: assert property (
    $changed(chan_o) || $changed(cfg_o) |-> conv_start_o)
    else $error("settings changed off start");
  a_nak_busy: assert property (conv_busy_o |-> !sda_oe_o)
    else $error("acknowledge while converting");
  a_oe_scl_low: assert property ($changed(sda_oe_o) |-> !scl_i)
    else $error("data pin moved with clock high");
  a_sw_idle: assert property (!conv_busy_o && !$past(conv_busy_o)
    |-> !sw_en_o) else $error("switch pulse while idle");
  a_sw_int_gap: assert property (sw_en_o && !use_ext_clk_i |=>
    !sw_en_o [*8]) else $error("internal switch rate too fast");
  a_sda_zero: assert property (sda_oe_o |-> !sda_o)
    else $error("data pin driven high");
  cover property (conv_start_o);
  cover property (sda_oe_o);
  cover property (sw_en_o && use_ext_clk_i);
endmodule
bind gcs_core gcs_core_checker #(.CONV_CYCLES(CONV_CYCLES)) u_chk (
  .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl_i), .sda_i(sda_i),
  .sda_o(sda_o), .sda_oe_o(sda_oe_o), .own_addr_i(own_addr_i),
  .use_ext_clk_i(use_ext_clk_i), .ext_clk_i(ext_clk_i),
  .conv_busy_o(conv_busy_o), .conv_start_o(conv_start_o),
  .chan_o(chan_o), .cfg_o(cfg_o), .sw_en_o(sw_en_o),
  .rd_data_i(rd_data_i));
`default_nettype wire

//--- verif/gcs_i2c_master.sv
// Bus master model driving SCL and pulling SDA, 64 ns bit time.
// Assumes SDA has a pull-up outside; SCL idles high between frames.
`timescale 1ns/1ps
`default_nettype none
module gcs_i2c_master (
  output logic      scl_o,
  output logic      sda_oe_o,
  input  wire logic sda_i
);
  initial begin
    scl_o    = 1'b1;
    sda_oe_o = 1'b0;
  end
  task automatic start();
    sda_oe_o = 1'b1;
    #32 scl_o = 1'b0;
  endtask
  // Byte MSB first, then acknowledge sampled on the ninth rise
  task automatic xbyte(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) begin
      #16 sda_oe_o = ~b[i];
      #16 scl_o = 1'b1;
      #32 scl_o = 1'b0;
    end
    #16 sda_oe_o = 1'b0;
    #16 scl_o = 1'b1;
    ack = ~sda_i;
    #32 scl_o = 1'b0;
  endtask
  // Read byte MSB first, then leave the ninth bit released (NAK)
  task automatic rbyte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      #16 sda_oe_o = 1'b0;
      #16 scl_o = 1'b1;
      b[i] = sda_i;
      #32 scl_o = 1'b0;
    end
    #16 sda_oe_o = 1'b0;
    #16 scl_o = 1'b1;
    #32 scl_o = 1'b0;
  endtask
  task automatic stop();
    #16 sda_oe_o = 1'b1;
    #16 scl_o = 1'b1;
    #32 sda_oe_o = 1'b0;
    #64;
  endtask
endmodule
`default_nettype wire

//--- verif/tb_top.sv
// Bench for the broadcast sync slave with a bus master model.
// Assumes a shortened conversion length for simulation.
`timescale 1ns/1ps
`default_nettype none
`include "gcs_map.svh"
module tb_top;
  import gcs_pkg::*;
  localparam int unsigned CONV = 2000;
  logic       clk_i;
  logic       rst_n_i;
  logic       use_ext_clk_i;
  logic       ext_clk_i;
  logic [6:0] own_addr_i;
  logic [7:0] rd_data_i;
  logic       scl;
  logic       m_oe;
  logic       sda_oe;
  logic       conv_busy_o;
  logic       conv_start_o;
  logic       sw_en_o;
  logic [7:0] chan_o;
  logic [7:0] cfg_o;
  wire logic  sda_w;
  int         num_errors;
  int         n_compared;
  int         n_starts;
  int         n_sw;
  int         n_ext;
  assign sda_w = ~(m_oe | sda_oe);
  gcs_i2c_master m (.scl_o(scl), .sda_oe_o(m_oe), .sda_i(sda_w));
  gcs_core #(.CONV_CYCLES(CONV)) dut (
    .clk_i(clk_i), .rst_n_i(rst_n_i), .scl_i(scl), .sda_i(sda_w),
    .sda_o(), .sda_oe_o(sda_oe), .own_addr_i(own_addr_i),
    .use_ext_clk_i(use_ext_clk_i), .ext_clk_i(ext_clk_i),
    .conv_busy_o(conv_busy_o), .conv_start_o(conv_start_o),
    .chan_o(chan_o), .cfg_o(cfg_o), .sw_en_o(sw_en_o),
    .rd_data_i(rd_data_i));
  initial begin
    clk_i = 1'b0;
    forever #2.5 clk_i = ~clk_i;
  end
  initial begin
    ext_clk_i = 1'b0;
    forever #10 ext_clk_i = ~ext_clk_i;
  end
  always @(posedge clk_i) begin
    if (conv_start_o === 1'b1) n_starts++;
    if (conv_busy_o === 1'b1 && sw_en_o === 1'b1) n_sw++;
  end
  always @(posedge ext_clk_i) if (conv_busy_o === 1'b1) n_ext++;
  // ==========================================
  // Shared tasks
  task automatic stop_test();
    $display("errors %0d compared %0d", num_errors, n_compared);
    if (num_errors == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t got %0h exp %0h", $time, got, exp);
    end
  endtask
  task automatic xfer(input logic [7:0] a, input int n,
                      input logic [15:0] d, input logic ea);
    logic ack;
    int   s0;
    s0 = n_starts;
    m.start();
    m.xbyte(a, ack);
    check({7'h00, ack}, {7'h00, ea});
    for (int i = 0; i < n; i++) begin
      m.xbyte(d[15-8*i -: 8], ack);
      check({7'h00, ack}, 8'h01);
    end
    m.stop();
    check(8'(n_starts - s0), {7'h00, ea});
  endtask
  task automatic wait_idle();
    int k;
    k = 0;
    while (conv_busy_o !== 1'b0 && k < 4000) begin
      @(posedge clk_i);
      k++;
    end
    if (k == 4000) begin
      num_errors++;
      stop_test();
    end
  endtask
  // ==========================================
  // Scenarios
  task automatic t_busy();
    check(chan_o, 8'h80);
    check(cfg_o, 8'h00);
    xfer(8'hEE, 0, 16'h0000, 1'b0);
  endtask
  task automatic t_sync();
    wait_idle();
    xfer(8'hEF, 0, 16'h0000, 1'b0);
    n_sw = 0;
    xfer(8'hEE, 0, 16'h0000, 1'b1);
    check(chan_o, 8'h80);
    check(cfg_o, 8'h00);
    wait_idle();
    check(8'(n_sw), 8'(CONV / `GCS_SW_INT_DIV));
  endtask
  task automatic t_read();
    logic       ack;
    logic [7:0] b;
    int         s0;
    wait_idle();
    s0 = n_starts;
    m.start();
    m.xbyte(8'h49, ack);
    check({7'h00, ack}, 8'h01);
    m.rbyte(b);
    check(b, 8'h5A);
    m.stop();
    check(8'(n_starts - s0), 8'h01);
  endtask
  task automatic t_write();
    wait_idle();
    xfer(8'hEE, 1, 16'h3500, 1'b1);
    check(chan_o, 8'h35);
    check(cfg_o, 8'h00);
    wait_idle();
    xfer(8'h48, 2, 16'h12A5, 1'b1);
    check(chan_o, 8'h12);
    check(cfg_o, 8'hA5);
    wait_idle();
    xfer(8'h28, 0, 16'h0000, 1'b0);
  endtask
  task automatic t_ext();
    int d;
    wait_idle();
    @(posedge clk_i);
    use_ext_clk_i <= 1'b1;
    n_sw = 0;
    n_ext = 0;
    xfer(8'hEE, 0, 16'h0000, 1'b1);
    wait_idle();
    d = 5 * n_sw - 2 * n_ext;
    check({7'h00, d >= -10 && d <= 10}, 8'h01);
  endtask
  initial begin
    num_errors = 0;
    n_compared = 0;
    n_starts = 0;
    rst_n_i = 1'b0;
    use_ext_clk_i = 1'b0;
    own_addr_i = 7'h24;
    rd_data_i = 8'h5A;
    repeat (2) @(posedge clk_i);
    rst_n_i <= 1'b1;
    @(posedge clk_i);
    t_busy();
    t_sync();
    t_write();
    t_read();
    t_ext();
    stop_test();
  end
endmodule
`default_nettype wire
